// ==== design/tcc_capture_channel.sv ====
/*
 one capture channel: pin synchroniser, edge detect, source select, capture
 register and sticky event flag; assumes the timer drives tick-free count
*/
`timescale 1ns/1ps
`include "tcc_defs.svh"

module tcc_capture_channel
(
   input  wire logic           core_clk,
   input  wire logic           resetn,
   input  wire logic           pin_in,
   input  wire logic           radio_event,
   input  wire logic           running,
   input  wire tcc_pkg::tcc_count_t count,
   input  wire logic [7:0]     ctl,
   input  wire logic           flag_clear,
   output logic                event_flag,
   output tcc_pkg::tcc_count_t capture_value
);
   import tcc_pkg::*;

   logic      sync_a;
   logic      sync_b;
   logic      pin_prev;
   tcc_edge_e edge_sel;
   logic      src_radio;
   logic      rise;
   logic      fall;
   logic      pin_hit;
   logic      capture;

   // pin decode; only sync_b and later stages are looked at
   assign edge_sel  = tcc_edge_e'(ctl[`TCC_CC_EDGE_LSB +: 2]);
   assign src_radio = ctl[`TCC_CC_SRC_BIT];
   assign rise      = sync_b & ~pin_prev;
   assign fall      = ~sync_b & pin_prev;
   assign pin_hit   = (edge_sel == TCC_EDGE_RISING  && rise) ||
                      (edge_sel == TCC_EDGE_FALLING && fall) ||
                      (edge_sel == TCC_EDGE_ANY     && (rise || fall));
   // radio source ignores the pin edge setting
   assign capture   = running && (src_radio ? radio_event : pin_hit);

   // two-flop synchroniser, pulses shorter than a clock may be missed
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         sync_a   <= 1'b0;
         sync_b   <= 1'b0;
         pin_prev <= 1'b0;
      end
      else
      begin
         sync_a   <= pin_in;
         sync_b   <= sync_a;
         pin_prev <= sync_b;
      end
   end

   // capture register and flag; a new capture beats a clear
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         capture_value <= `TCC_COUNT_ZERO;
         event_flag    <= 1'b0;
      end
      else
      begin
         if (capture)
            capture_value <= count;
         if (capture)
            event_flag <= 1'b1;
         else if (flag_clear)
            event_flag <= 1'b0;
      end
   end

endmodule

// ==== design/tcc_defs.svh ====
/*
 register offsets, field positions, reset values and prescaler reload values of the
 16-bit capture timer; assumes a byte-wide register port
*/
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH

// register offsets (byte index on the register port)
`define TCC_OFS_COUNT_LOW     4'h0
`define TCC_OFS_COUNT_HIGH    4'h1
`define TCC_OFS_CONTROL       4'h2
`define TCC_OFS_MASK          4'h3
`define TCC_OFS_PERIOD_LOW    4'h4
`define TCC_OFS_PERIOD_HIGH   4'h5
`define TCC_OFS_CHCTL_BASE    4'h6
`define TCC_OFS_CAP_BASE      4'h9
`define TCC_OFS_RADIO_MASK    4'hf

// timer_control_status fields
`define TCC_CTL_MODE_LSB      0
`define TCC_CTL_DIV_LSB       2
`define TCC_CTL_TCF_BIT       4
`define TCC_CTL_CHF_LSB       5

// timer_mask_register fields
`define TCC_MSK_TCM_BIT       0

// channel_control fields
`define TCC_CC_EDGE_LSB       0
`define TCC_CC_SRC_BIT        2
`define TCC_CC_IM_BIT         3

// reset values
`define TCC_RST_CONTROL       8'h00
`define TCC_RST_MASK          8'h01
`define TCC_RST_CHCTL         8'h00
`define TCC_RST_PERIOD        16'hffff
`define TCC_RST_RADIO_MASK    8'h00

// counter limits
`define TCC_COUNT_ZERO        16'h0000
`define TCC_COUNT_TOP         16'hffff

// prescaler reload values (division minus one)
`define TCC_DIV1_LAST         7'h00
`define TCC_DIV8_LAST         7'h07
`define TCC_DIV32_LAST        7'h1f
`define TCC_DIV128_LAST       7'h7f

`endif

// ==== design/tcc_pkg.sv ====
/*
 types shared by the capture timer files; assumes tcc_defs.svh for numbers
*/
package tcc_pkg;

   // count mode field of timer_control_status
   typedef enum logic [1:0] {
      TCC_MODE_HALT   = 2'b00,
      TCC_MODE_FREE   = 2'b01,
      TCC_MODE_MODULO = 2'b10,
      TCC_MODE_UPDOWN = 2'b11
   } tcc_mode_e;

   // capture edge select of channel_control
   typedef enum logic [1:0] {
      TCC_EDGE_NONE    = 2'b00,
      TCC_EDGE_RISING  = 2'b01,
      TCC_EDGE_FALLING = 2'b10,
      TCC_EDGE_ANY     = 2'b11
   } tcc_edge_e;

   typedef logic [15:0] tcc_count_t;

endpackage

// ==== design/tcc_timer.sv ====
/*
 16-bit timer/counter with prescaler, three capture channels and a byte-wide
 register port; assumes a system tick strobe from the clock controller, pins
 synchronous-safe through the channel synchronisers, and a radio event level
 per radio interrupt source
*/
`timescale 1ns/1ps
`include "tcc_defs.svh"

// Notes on behaviour
// - 16-bit counter steps one per tick edge
// - prescaler divides tick by 1, 8, 32, 128
// - low byte read latches high byte
// - any low byte write clears counter
// - nonzero mode runs, zero halts holding value
// - free mode wraps ffff to zero
// - free wrap sets flag, mask gates request
// - modulo counts up to period value
// - modulo terminal sets flag, masked request
// - up/down ramps between zero and period
// - up/down never sets terminal flag
// - low byte write forces direction up
// - three channels, each own control register
// - capture copies counter on chosen edge
// - pin inputs synchronised; pulses exceed one clock
// - capture sets flag, channel mask gates request
// - source select picks pin or radio
// - enabled radio sources trigger capture
// - enabling mask over set flag re-requests
module tcc_timer
#(
   parameter int CHANNELS    = 3,
   parameter int RADIO_LINES = 8
)
(
   input  wire logic                   core_clk,
   input  wire logic                   resetn,
   input  wire logic                   sys_tick,
   input  wire logic [3:0]             reg_addr,
   input  wire logic [7:0]             reg_wdata,
   input  wire logic                   reg_write,
   input  wire logic                   reg_read,
   output logic [7:0]                  reg_rdata,
   input  wire logic [CHANNELS-1:0]    channel_pin,
   input  wire logic [RADIO_LINES-1:0] radio_irq,
   output logic                        timer_irq,
   output tcc_pkg::tcc_count_t         count_value
);
   import tcc_pkg::*;

   logic [7:0]          control;
   logic [7:0]          mask_reg;
   logic [7:0]          radio_mask;
   tcc_count_t          period;
   logic [7:0]          count_high_latch;
   logic [6:0]          prescale;
   logic                count_down;
   logic                tc_flag;
   logic                irq_level_q;
   logic [7:0]          chctl [CHANNELS];
   tcc_count_t          capv [CHANNELS];
   logic [CHANNELS-1:0] ch_flag;

   tcc_mode_e           mode;
   logic [6:0]          div_last;
   logic                running;
   logic                active_edge;
   logic                wr_low;
   logic                rd_low;
   logic                wr_ctl;
   logic                at_top;
   logic                at_period;
   logic                tc_event;
   logic                radio_event;
   tcc_count_t          next_count;
   logic                next_down;
   logic [7:0]          next_rdata;
   logic                irq_level;
   logic [CHANNELS-1:0] ch_irq;
   tcc_count_t          count;

   // register strobes
   assign wr_low = reg_write && reg_addr == `TCC_OFS_COUNT_LOW;
   assign rd_low = reg_read && reg_addr == `TCC_OFS_COUNT_LOW;
   assign wr_ctl = reg_write && reg_addr == `TCC_OFS_CONTROL;

   // mode and prescale decode
   assign mode     = tcc_mode_e'(control[`TCC_CTL_MODE_LSB +: 2]);
   assign running  = mode != TCC_MODE_HALT;
   assign div_last = (control[`TCC_CTL_DIV_LSB +: 2] == 2'd0) ? `TCC_DIV1_LAST :
                     (control[`TCC_CTL_DIV_LSB +: 2] == 2'd1) ? `TCC_DIV8_LAST :
                     (control[`TCC_CTL_DIV_LSB +: 2] == 2'd2) ? `TCC_DIV32_LAST :
                                                                `TCC_DIV128_LAST;
   assign active_edge = running && sys_tick && prescale == `TCC_DIV1_LAST;

   // terminal decode
   assign at_top    = count == `TCC_COUNT_TOP;
   assign at_period = count == period;
   // up/down reaching the period is not a terminal event
   assign tc_event  = active_edge &&
                      ((mode == TCC_MODE_FREE && at_top) ||
                       (mode == TCC_MODE_MODULO && at_period));

   // next count per mode
   always_comb
   begin
      next_count = count;
      next_down  = count_down;
      if (active_edge)
      begin
         unique case (mode)
            TCC_MODE_HALT:
               next_count = count;
            TCC_MODE_FREE:
               next_count = at_top ? `TCC_COUNT_ZERO : count + 16'h0001;
            TCC_MODE_MODULO:
               next_count = at_period ? `TCC_COUNT_ZERO : count + 16'h0001;
            TCC_MODE_UPDOWN:
            begin
               // turn around at either end; period of zero just holds at zero
               if (!count_down && (at_period || at_top))
               begin
                  next_down  = 1'b1;
                  next_count = (count == `TCC_COUNT_ZERO) ? count : count - 16'h0001;
               end
               else if (count_down && count == `TCC_COUNT_ZERO)
               begin
                  next_down  = 1'b0;
                  next_count = at_period ? count : count + 16'h0001;
               end
               else
                  next_count = count_down ? count - 16'h0001 : count + 16'h0001;
            end
         endcase
      end
      if (wr_low)
      begin
         next_count = `TCC_COUNT_ZERO;
         next_down  = 1'b0;
      end
   end

   // counter, direction and prescaler; the prescaler restarts with the counter
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         count      <= `TCC_COUNT_ZERO;
         count_down <= 1'b0;
         prescale   <= `TCC_DIV1_LAST;
      end
      else
      begin
         count      <= next_count;
         count_down <= next_down;
         if (wr_low || !running)
            prescale <= div_last;
         else if (sys_tick)
            prescale <= (prescale == `TCC_DIV1_LAST) ? div_last : prescale - 7'h01;
      end
   end

   // configuration registers
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         control    <= `TCC_RST_CONTROL;
         mask_reg   <= `TCC_RST_MASK;
         radio_mask <= `TCC_RST_RADIO_MASK;
         period     <= `TCC_RST_PERIOD;
      end
      else if (reg_write)
      begin
         if (reg_addr == `TCC_OFS_CONTROL)
            control[3:0] <= reg_wdata[3:0];
         if (reg_addr == `TCC_OFS_MASK)
            mask_reg <= {7'h00, reg_wdata[`TCC_MSK_TCM_BIT]};
         if (reg_addr == `TCC_OFS_RADIO_MASK)
            radio_mask <= reg_wdata;
         if (reg_addr == `TCC_OFS_PERIOD_LOW)
            period[7:0] <= reg_wdata;
         if (reg_addr == `TCC_OFS_PERIOD_HIGH)
            period[15:8] <= reg_wdata;
      end
   end

   // terminal flag: an event wins over a zero written at the same edge
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         tc_flag <= 1'b0;
      else if (tc_event)
         tc_flag <= 1'b1;
      else if (wr_ctl && !reg_wdata[`TCC_CTL_TCF_BIT])
         tc_flag <= 1'b0;
   end

   // high byte is buffered only by a low byte read
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         count_high_latch <= 8'h00;
      else if (rd_low)
         count_high_latch <= count[15:8];
   end

   // radio trigger is any enabled radio source
   assign radio_event = |(radio_irq & radio_mask);

   // channel blocks and their control registers
   generate
      for (genvar ch = 0; ch < CHANNELS; ch++)
      begin : g_ch
         logic ctl_hit;
         assign ctl_hit = reg_write && reg_addr == 4'(`TCC_OFS_CHCTL_BASE + ch);

         always_ff @(posedge core_clk or negedge resetn)
         begin
            if (!resetn)
               chctl[ch] <= `TCC_RST_CHCTL;
            else if (ctl_hit)
               chctl[ch] <= {4'h0, reg_wdata[3:0]};
         end

         tcc_capture_channel u_chan
         (
            .core_clk      (core_clk),
            .resetn        (resetn),
            .pin_in        (channel_pin[ch]),
            .radio_event   (radio_event),
            .running       (running),
            .count         (count),
            .ctl           (chctl[ch]),
            .flag_clear    (wr_ctl && !reg_wdata[`TCC_CTL_CHF_LSB + ch]),
            .event_flag    (ch_flag[ch]),
            .capture_value (capv[ch])
         );

         assign ch_irq[ch] = ch_flag[ch] && chctl[ch][`TCC_CC_IM_BIT];
      end
   endgenerate

   // request is flag and mask; a rising level is a new request
   assign irq_level = (tc_flag && mask_reg[`TCC_MSK_TCM_BIT]) || (|ch_irq);

   // one-cycle request pulse on each rise, so a mask set over a pending flag
   // raises a fresh request
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         irq_level_q <= 1'b0;
      else
         irq_level_q <= irq_level;
   end
   assign timer_irq = irq_level && !irq_level_q;

   // read mux; channel captures sit at base plus two per channel
   always_comb
   begin
      next_rdata = 8'h00;
      unique case (reg_addr)
         `TCC_OFS_COUNT_LOW:   next_rdata = count[7:0];
         `TCC_OFS_COUNT_HIGH:  next_rdata = count_high_latch;
         `TCC_OFS_CONTROL:     next_rdata = {ch_flag, tc_flag, control[3:0]};
         `TCC_OFS_MASK:        next_rdata = mask_reg;
         `TCC_OFS_PERIOD_LOW:  next_rdata = period[7:0];
         `TCC_OFS_PERIOD_HIGH: next_rdata = period[15:8];
         4'h6:                 next_rdata = chctl[0];
         4'h7:                 next_rdata = chctl[1];
         4'h8:                 next_rdata = chctl[2];
         4'h9:                 next_rdata = capv[0][7:0];
         4'ha:                 next_rdata = capv[0][15:8];
         4'hb:                 next_rdata = capv[1][7:0];
         4'hc:                 next_rdata = capv[1][15:8];
         4'hd:                 next_rdata = capv[2][7:0];
         4'he:                 next_rdata = capv[2][15:8];
         `TCC_OFS_RADIO_MASK:  next_rdata = radio_mask;
      endcase
   end

   // read data stands the cycle after the strobe only
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         reg_rdata <= 8'h00;
      else if (reg_read)
         reg_rdata <= next_rdata;
      else
         reg_rdata <= 8'h00;
   end

   assign count_value = count;

endmodule

// ==== tb/tcc_far_side.sv ====
/*
 far-side model: capture pins and radio event lines; assumes the bench
 calls one task at a time
*/
`timescale 1ns/1ps

module tcc_far_side
(
   input  wire logic  core_clk,
   output logic [2:0] channel_pin,
   output logic [7:0] radio_irq
);
   initial
   begin
      channel_pin = 3'h0;
      radio_irq   = 8'h00;
   end

   // levels held six cycles, far past the one clock the synchroniser needs
   task automatic set_pins(input logic [2:0] v);
      @(posedge core_clk);
      channel_pin <= v;
      repeat (6) @(posedge core_clk);
   endtask

   // short radio event; capture is level-sensitive so it repeats meanwhile
   task automatic radio_pulse(input logic [7:0] v);
      @(posedge core_clk);
      radio_irq <= v;
      repeat (2) @(posedge core_clk);
      radio_irq <= 8'h00;
      repeat (6) @(posedge core_clk);
   endtask
endmodule

// ==== tb/tcc_timer_asserts.sv ====
/*
 port checker for the capture timer; assumes it is bound to tcc_timer
 and that sys_tick mostly stays high
*/
`timescale 1ns/1ps

module tcc_timer_asserts
#(
   parameter int CHANNELS    = 3,
   parameter int RADIO_LINES = 8
)
(
   input wire logic                   core_clk,
   input wire logic                   resetn,
   input wire logic                   sys_tick,
   input wire logic [3:0]             reg_addr,
   input wire logic [7:0]             reg_wdata,
   input wire logic                   reg_write,
   input wire logic                   reg_read,
   input wire logic [7:0]             reg_rdata,
   input wire logic [CHANNELS-1:0]    channel_pin,
   input wire logic [RADIO_LINES-1:0] radio_irq,
   input wire logic                   timer_irq,
   input wire tcc_pkg::tcc_count_t    count_value
);
   import tcc_pkg::*;
   default clocking dclk @(posedge core_clk);
   endclocking
   default disable iff (!resetn);

   // decoded writes and the spacing each divider demands
   wire        clr  = reg_write && reg_addr == 4'h0;
   wire        ctlw = reg_write && reg_addr == 4'h2;
   logic [1:0] mode_q;
   logic [1:0] div_q;
   logic [7:0] high_q;
   logic [7:0] gap;
   logic       fresh;
   tcc_count_t last_q;
   wire        chg  = count_value != last_q;
   wire  [7:0] need = div_q == 2'h0 ? 8'h01 : div_q == 2'h1 ? 8'h08 :
                      div_q == 2'h2 ? 8'h20 : 8'h80;

   // gap saturates at ff, meaning unknown, after any control write
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         mode_q <= 2'h0;
         div_q  <= 2'h0;
         high_q <= 8'h00;
         last_q <= 16'h0000;
         gap    <= 8'hff;
         fresh  <= 1'b0;
      end
      else
      begin
         last_q <= count_value;
         gap    <= (ctlw || clr) ? 8'hff : chg ? 8'h01 : gap == 8'hff ? gap : gap + 8'h01;
         fresh  <= clr ? 1'b1 : (chg && count_value != 16'h0000) ? 1'b0 : fresh;
         if (reg_read && reg_addr == 4'h0)
            high_q <= count_value[15:8];
         if (ctlw)
            mode_q <= reg_wdata[1:0];
         if (ctlw)
            div_q <= reg_wdata[3:2];
      end
   end

   property p_low_read;
      reg_read && reg_addr == 4'h0 |=> reg_rdata == last_q[7:0];
   endproperty
   a_low_read: assert property (p_low_read)
      else $error("low count byte wrong");

   property p_high_read;
      reg_read && reg_addr == 4'h1 |=> reg_rdata == $past(high_q);
   endproperty
   a_high_read: assert property (p_high_read)
      else $error("high count byte not the latched one");

   property p_clear;
      clr |=> count_value == 16'h0000;
   endproperty
   a_clear: assert property (p_clear)
      else $error("count not cleared");

   property p_step;
      chg && !$past(clr) |-> count_value == last_q + 16'h0001 ||
         count_value == last_q - 16'h0001 || count_value == 16'h0000;
   endproperty
   a_step: assert property (p_step)
      else $error("count moved by more than one");

   property p_spacing;
      chg && !$past(clr) |-> gap >= need;
   endproperty
   a_spacing: assert property (p_spacing)
      else $error("count stepped faster than the divider");

   property p_halt;
      mode_q == 2'h0 && !clr |=> $stable(count_value);
   endproperty
   a_halt: assert property (p_halt)
      else $error("halted count moved");

   property p_wrap;
      chg && last_q == 16'hffff && mode_q == 2'h1 |-> count_value == 16'h0000;
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("free count did not wrap to zero");

   property p_up_first;
      fresh && chg |-> count_value <= 16'h0001;
   endproperty
   a_up_first: assert property (p_up_first)
      else $error("first step after clear not upward");

   property p_irq_pulse;
      timer_irq |=> !timer_irq;
   endproperty
   a_irq_pulse: assert property (p_irq_pulse)
      else $error("interrupt request longer than one cycle");

   c_wrap: cover property (chg && last_q == 16'hffff);
   c_irq: cover property (timer_irq);
   c_capture_read: cover property (reg_read && reg_addr == 4'h9);
endmodule

bind tcc_timer tcc_timer_asserts #(.CHANNELS(CHANNELS), .RADIO_LINES(RADIO_LINES))
   tcc_timer_asserts_inst (.core_clk(core_clk), .resetn(resetn), .sys_tick(sys_tick),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
   .reg_read(reg_read), .reg_rdata(reg_rdata), .channel_pin(channel_pin),
   .radio_irq(radio_irq), .timer_irq(timer_irq), .count_value(count_value));

// ==== tb/test_timer16_capture_counter.sv ====
/*
 self-checking bench for the capture timer; assumes the far-side model
 drives pins and radio lines and the checker is bound to the timer
*/
`timescale 1ns/1ps

module test_timer16_capture_counter;
   import tcc_pkg::*;
   logic       core_clk;
   logic       resetn;
   logic       sys_tick = 1'b1;
   logic       tick_half = 1'b0;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata;
   logic       reg_write;
   logic       reg_read;
   logic [7:0] reg_rdata;
   logic [2:0] channel_pin;
   logic [7:0] radio_irq;
   logic       timer_irq;
   logic       seen;
   tcc_count_t count_value;
   int         failures;
   int         num_checks;
   int         cycles = 0;

   tcc_timer tcc_timer_inst (.core_clk(core_clk), .resetn(resetn), .sys_tick(sys_tick),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .channel_pin(channel_pin),
      .radio_irq(radio_irq), .timer_irq(timer_irq), .count_value(count_value));
   tcc_far_side tcc_far_side_inst (.core_clk(core_clk), .channel_pin(channel_pin),
      .radio_irq(radio_irq));

   initial
   begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   // tick strobe every cycle, or every other cycle so the prescaler sees gaps
   always @(posedge core_clk)
      sys_tick <= tick_half ? ~sys_tick : 1'b1;

   // the free-running wrap alone takes 65536 cycles
   always @(posedge core_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 90000)
      begin
         failures = failures + 1;
         results();
      end
   end

   task automatic results();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   // register port: one-cycle strobes, read data in the following cycle
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge core_clk);
      reg_write <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
      @(posedge core_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge core_clk);
      reg_read <= 1'b0;
      #1;
      if (what != "")
         chk(what, {8'h00, exp}, {8'h00, reg_rdata});
   endtask

   // waits for the next count change, checks value and cycles taken
   task automatic next_cnt(input tcc_count_t exp, input int gap, input string what);
      tcc_count_t was;
      int n;
      #1 was = count_value;
      n = 0;
      while (count_value === was && n < 400)
      begin
         @(posedge core_clk);
         #1 n++;
      end
      chk(what, exp, count_value);
      if (gap > 0)
         chk("spacing", gap[15:0], n[15:0]);
   endtask

   task automatic wait_cnt(input tcc_count_t v, input int lim);
      int n;
      n = 0;
      while (count_value !== v && n < lim)
      begin
         @(posedge core_clk);
         #1 n++;
      end
      chk("reach", v, count_value);
   endtask

   task automatic irq_win(input logic exp, input string what);
      seen = 1'b0;
      repeat (10)
      begin
         #1 seen = seen | timer_irq;
         @(posedge core_clk);
      end
      chk(what, {15'h0, exp}, {15'h0, seen});
   endtask

   task automatic t_reset();
      rd(4'h2, 8'h00, "ctl rst");
      rd(4'h3, 8'h01, "mask rst");
      rd(4'h4, 8'hff, "per lo rst");
      rd(4'h5, 8'hff, "per hi rst");
      for (int i = 6; i < 9; i++)
         rd(i[3:0], 8'h00, "chctl rst");
      rd(4'hf, 8'h00, "radio mask rst");
      wr(4'h1, 8'h5a);
      rd(4'h1, 8'h00, "high read only");
   endtask

   task automatic t_prescale();
      int n;
      for (int d = 0; d < 4; d++)
      begin
         n = d == 0 ? 1 : d == 1 ? 8 : d == 2 ? 32 : 128;
         wr(4'h0, 8'h00);
         wr(4'h2, {4'h0, d[1:0], 2'h1});
         next_cnt(16'h0001, 0, "first step");
         next_cnt(16'h0002, n, "second step");
         wr(4'h2, 8'h00);
      end
      // divide by 8 with a tick on every other clock gives 16 clocks a step
      tick_half <= 1'b1;
      wr(4'h0, 8'h00);
      wr(4'h2, 8'h05);
      next_cnt(16'h0001, 0, "half tick first");
      next_cnt(16'h0002, 16, "half tick step");
      wr(4'h2, 8'h00);
      tick_half <= 1'b0;
   endtask

   // the high byte must be the one buffered by the last low read
   task automatic t_latch();
      wr(4'h0, 8'h00);
      wr(4'h2, 8'h01);
      wait_cnt(16'h00f0, 300);
      rd(4'h0, 8'h00, "");
      wait_cnt(16'h0110, 300);
      rd(4'h1, 8'h00, "high latched");
      rd(4'h0, 8'h00, "");
      rd(4'h1, 8'h01, "high relatched");
      wr(4'h2, 8'h00);
   endtask

   task automatic t_modulo();
      wr(4'h4, 8'h04);
      wr(4'h5, 8'h00);
      wr(4'h0, 8'h00);
      wr(4'h2, 8'h02);
      for (int i = 1; i < 7; i++)
         next_cnt(16'(i % 5), 0, "mod step");
      wr(4'h2, 8'h10);
      wr(4'h3, 8'h00);
      wr(4'h3, 8'h01);
      irq_win(1'b1, "mask over flag");
      rd(4'h2, 8'h10, "mod flag");
      wr(4'h2, 8'h00);
      rd(4'h2, 8'h00, "flag clr");
   endtask

   task automatic t_updown();
      wr(4'h4, 8'h03);
      wr(4'h0, 8'h00);
      wr(4'h2, 8'h03);
      for (int i = 1; i < 10; i++)
         next_cnt(16'(i < 4 ? i : i < 7 ? 6 - i : i - 6), 0, "ud step");
      next_cnt(16'h0002, 0, "ud down");
      wr(4'h0, 8'h00);
      #1 chk("ud clr", 16'h0000, count_value);
      next_cnt(16'h0001, 0, "ud up");
      rd(4'h2, 8'h03, "ud no flag");
      wr(4'h2, 8'h00);
   endtask

   // the first step comes at once on start, the second 128 clocks later;
   // the count then stays at 2 while the pins move
   task automatic t_capture();
      wr(4'h6, 8'h03);
      wr(4'h7, 8'h09);
      wr(4'h8, 8'h02);
      wr(4'h0, 8'h00);
      wr(4'h2, 8'h0d);
      repeat (140) @(posedge core_clk);
      fork
         tcc_far_side_inst.set_pins(3'h7);
         irq_win(1'b1, "masked cap irq");
      join
      rd(4'h2, 8'h6d, "rise flags");
      rd(4'h9, 8'h02, "cap0");
      rd(4'hb, 8'h02, "cap1");
      rd(4'hc, 8'h00, "cap1 hi");
      wr(4'h2, 8'h0d);
      fork
         tcc_far_side_inst.set_pins(3'h0);
         irq_win(1'b0, "unmasked cap irq");
      join
      rd(4'h2, 8'had, "fall flags");
      rd(4'hd, 8'h02, "cap2");
      wr(4'h6, 8'h00);
      wr(4'h2, 8'h0d);
      tcc_far_side_inst.set_pins(3'h7);
      rd(4'h2, 8'h4d, "no edge flags");
      wr(4'h2, 8'h00);
      repeat (300) @(posedge core_clk);
      rd(4'h0, 8'h02, "halted");
      wr(4'h0, 8'h5a);
      rd(4'h0, 8'h00, "cleared");
   endtask

   task automatic t_radio();
      wr(4'h8, 8'h04);
      wr(4'hf, 8'h08);
      wr(4'h2, 8'h01);
      tcc_far_side_inst.radio_pulse(8'hf7);
      tcc_far_side_inst.set_pins(3'h0);
      rd(4'h2, 8'h01, "radio masked off");
      tcc_far_side_inst.radio_pulse(8'h08);
      rd(4'h2, 8'h81, "radio capture");
      wr(4'h2, 8'h00);
   endtask

   task automatic t_wrap();
      wr(4'h0, 8'h00);
      wr(4'h2, 8'h01);
      wait_cnt(16'hffff, 70000);
      next_cnt(16'h0000, 0, "wrap");
      irq_win(1'b1, "wrap irq");
      rd(4'h2, 8'h11, "wrap flag");
      wr(4'h2, 8'h00);
   endtask

   initial
   begin
      resetn     = 1'b0;
      reg_addr   = 4'h0;
      reg_wdata  = 8'h00;
      reg_write  = 1'b0;
      reg_read   = 1'b0;
      failures   = 0;
      num_checks = 0;
      repeat (2) @(posedge core_clk);
      resetn <= 1'b1;
      t_reset();
      t_prescale();
      t_latch();
      t_modulo();
      t_updown();
      t_capture();
      t_radio();
      t_wrap();
      results();
   end
endmodule
